//--- hdl/xtrig_pkg.sv
// Constants shared by the cross-trigger capture core and its hub
package xtrig_pkg;
  // Sample clock rate in hertz
  localparam int unsigned SAMPLE_CLOCK_HZ     = 50_000_000;
  // Delay from trigger input to its acknowledge, in sample cycles
  localparam int unsigned IN_ACK_DELAY        = 1;
  // Delay from trigger event to trigger output, in sample cycles
  localparam int unsigned OUT_DELAY           = 9;
  // Hub target rate in hertz and default incoming hub clock rate
  localparam int unsigned HUB_TARGET_HZ       = 100_000_000;
  localparam int unsigned HUB_INPUT_FREQ_HZ   = 200_000_000;
  // Default user chain index for the hub
  localparam logic [2:0]  USER_CHAIN_DEFAULT  = 3'h1;
  // Width of the parallel word the hub moves to a core
  localparam int unsigned HUB_WORD_W          = 16;
  // Shift count width for the serial word
  localparam int unsigned HUB_CNT_W           = 4;
  // Delay counter width (covers OUT_DELAY)
  localparam int unsigned DLY_W               = 4;
  localparam logic [DLY_W-1:0] DLY_RESET      = 4'h0;

  // Output trigger states
  typedef enum logic [1:0] {
    TO_IDLE  = 2'b00,
    TO_WAIT  = 2'b01,
    TO_HIGH  = 2'b10,
    TO_DONE  = 2'b11
  } trig_out_state_t;

  // Clock division ratio from input rate to target, at least one
  function automatic int unsigned hub_div(input int unsigned inHz);
    hub_div = (inHz <= HUB_TARGET_HZ) ? 1 :
              (inHz + HUB_TARGET_HZ - 1) / HUB_TARGET_HZ;
  endfunction : hub_div
endpackage : xtrig_pkg

//--- hdl/debug_hub_link.sv
// Hub bridge from the user scan chain to a parallel word for the core
module debug_hub_link
  import xtrig_pkg::*;
#(
  parameter logic [2:0]  USER_CHAIN          = xtrig_pkg::USER_CHAIN_DEFAULT,
  parameter bit          ENABLE_CLK_DIVIDER  = 1'b0,
  parameter int unsigned hub_input_frequency = xtrig_pkg::HUB_INPUT_FREQ_HZ
) (
  input  wire logic                  ref_clk,
  input  wire logic                  sys_rst,
  input  wire logic [2:0]            scanSelect,
  input  wire logic                  scanShift,
  input  wire logic                  scanTdi,
  input  wire logic                  scanUpdate,
  output logic                       scanTdo,
  output logic                       hubTick,
  output logic [xtrig_pkg::HUB_WORD_W-1:0] hubWord,
  output logic                       hubWordValid,
  input  wire logic [xtrig_pkg::HUB_WORD_W-1:0] coreStatus
);
  localparam int unsigned DIV = hub_div(hub_input_frequency);
  localparam int unsigned DIV_N = ENABLE_CLK_DIVIDER ? DIV : 1;
  localparam logic [7:0] DIV_LAST = 8'(DIV_N - 1);

  logic [7:0]            divCnt_reg, divCnt_next;
  logic                  tick_reg, tick_next;
  logic [HUB_WORD_W-1:0] shift_reg, shift_next;
  logic [HUB_WORD_W-1:0] word_reg, word_next;
  logic                  valid_reg, valid_next;
  logic                  tdo_reg, tdo_next;
  logic                  chainHit;

  //////////////////////////////////////////////////////////////////////////
  // Only answer on our own user chain
  assign chainHit = (scanSelect == USER_CHAIN);

  always_comb begin
    divCnt_next = (divCnt_reg == DIV_LAST) ? 8'h00 : divCnt_reg + 8'h01;
    tick_next   = (divCnt_reg == DIV_LAST);
  end

  always_comb begin
    shift_next = shift_reg;
    word_next  = word_reg;
    valid_next = 1'b0;
    tdo_next   = tdo_reg;
    if (tick_reg && chainHit) begin
      if (scanShift) begin
        shift_next = {scanTdi, shift_reg[HUB_WORD_W-1:1]};
        tdo_next   = shift_reg[0];
      end else if (scanUpdate) begin
        word_next  = shift_reg;
        valid_next = 1'b1;
        shift_next = coreStatus;           // Capture status for read back
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      divCnt_reg <= 8'h00;
      tick_reg   <= 1'b0;
      shift_reg  <= '0;
      word_reg   <= '0;
      valid_reg  <= 1'b0;
      tdo_reg    <= 1'b0;
    end else begin
      divCnt_reg <= divCnt_next;
      tick_reg   <= tick_next;
      shift_reg  <= shift_next;
      word_reg   <= word_next;
      valid_reg  <= valid_next;
      tdo_reg    <= tdo_next;
    end
  end

  assign scanTdo      = tdo_reg;
  assign hubTick      = tick_reg;
  assign hubWord      = word_reg;
  assign hubWordValid = valid_reg;
endmodule : debug_hub_link

//--- hdl/logic_analyzer_cross_trigger.sv
// Capture core cross-trigger handshake with its hub bridge
module logic_analyzer_cross_trigger
  import xtrig_pkg::*;
#(
  // Default chain, override to avoid conflicts
  parameter logic [2:0]  USER_CHAIN          = xtrig_pkg::USER_CHAIN_DEFAULT,
  parameter bit          ENABLE_CLK_DIVIDER  = 1'b0,
  parameter int unsigned hub_input_frequency = xtrig_pkg::HUB_INPUT_FREQ_HZ
) (
  input  wire logic                  ref_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  armReq,
  input  wire logic                  trigCond,
  input  wire logic                  trigIn,
  output logic                       trigInAck,
  output logic                       trigOut,
  input  wire logic                  trigOutAck,
  output logic                       armed,
  output logic                       triggered,
  input  wire logic [2:0]            scanSelect,
  input  wire logic                  scanShift,
  input  wire logic                  scanTdi,
  input  wire logic                  scanUpdate,
  output logic                       scanTdo
);
  import xtrig_pkg::*;

  localparam logic [DLY_W-1:0] OUT_LAST = DLY_W'(OUT_DELAY - 1);

  trig_out_state_t       state_reg, state_next;
  logic                  inAck_reg, inAck_next;
  logic                  trigOut_reg, trigOut_next;
  logic [DLY_W-1:0]      dly_reg, dly_next;
  logic                  armed_reg, armed_next;
  logic                  trigd_reg, trigd_next;
  logic                  useIn_reg, useIn_next;
  logic                  hubArm, hubUseIn, hubDisarm;
  logic                  hubTick;
  logic [HUB_WORD_W-1:0] hubWord;
  logic                  hubWordValid;
  logic [HUB_WORD_W-1:0] coreStatus;
  logic                  fireEvent;
  logic                  rearm;

  //////////////////////////////////////////////////////////////////////////
  // Hub bridge instance, divider and chain settings passed down
  debug_hub_link #(
    .USER_CHAIN          (USER_CHAIN),
    .ENABLE_CLK_DIVIDER  (ENABLE_CLK_DIVIDER),
    .hub_input_frequency (hub_input_frequency)
  ) u_hub (
    .ref_clk      (ref_clk),
    .sys_rst      (sys_rst),
    .scanSelect   (scanSelect),
    .scanShift    (scanShift),
    .scanTdi      (scanTdi),
    .scanUpdate   (scanUpdate),
    .scanTdo      (scanTdo),
    .hubTick      (hubTick),
    .hubWord      (hubWord),
    .hubWordValid (hubWordValid),
    .coreStatus   (coreStatus)
  );

  // Hub command word: bit0 arm, bit1 enable trigger input, bit2 disarm
  assign hubArm    = hubWordValid & hubWord[0];
  assign hubUseIn  = hubWord[1];
  assign hubDisarm = hubWordValid & hubWord[2];
  assign rearm     = armReq | hubArm;

  // Status returned through the hub
  assign coreStatus = {{(HUB_WORD_W-6){1'b0}}, hubTick, useIn_reg,
                       trigOut_reg, inAck_reg, trigd_reg, armed_reg};

  //////////////////////////////////////////////////////////////////////////
  // Event when armed and input used or own condition true
  assign fireEvent = armed_reg & ((useIn_reg & trigIn) | trigCond);

  // Input acknowledge tracking
  always_comb begin
    inAck_next = inAck_reg;
    if (trigIn)
      inAck_next = 1'b1;
    else
      inAck_next = 1'b0;
  end

  // Arm and trigger-output sequencing
  always_comb begin
    state_next   = state_reg;
    dly_next     = dly_reg;
    armed_next   = armed_reg;
    trigd_next   = trigd_reg;
    trigOut_next = trigOut_reg;
    useIn_next   = hubWordValid ? hubUseIn : useIn_reg;
    unique case (state_reg)
      TO_IDLE: begin
        if (fireEvent) begin
          state_next = TO_WAIT;
          dly_next   = DLY_RESET;
          armed_next = 1'b0;
          trigd_next = 1'b1;
        end else if (hubDisarm) begin
          armed_next = 1'b0;
        end else if (rearm) begin
          armed_next = 1'b1;
        end
      end
      TO_WAIT: begin
        dly_next = dly_reg + 4'h1;
        if (dly_reg == OUT_LAST) begin
          trigOut_next = 1'b1;
          state_next   = TO_HIGH;
        end
      end
      TO_HIGH: begin
        if (trigOutAck) begin
          trigOut_next = 1'b0;
          state_next   = TO_DONE;
        end else if (rearm) begin
          trigOut_next = 1'b0;
          armed_next   = 1'b1;
          trigd_next   = 1'b0;
          state_next   = TO_IDLE;
        end
      end
      TO_DONE: begin
        if (rearm) begin
          armed_next = 1'b1;
          trigd_next = 1'b0;
          state_next = TO_IDLE;
        end
      end
    endcase
  end

  // Registers on the free-running sample clock
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg   <= TO_IDLE;
      inAck_reg   <= 1'b0;
      trigOut_reg <= 1'b0;
      dly_reg     <= DLY_RESET;
      armed_reg   <= 1'b0;
      trigd_reg   <= 1'b0;
      useIn_reg   <= 1'b1;
    end else begin
      state_reg   <= state_next;
      inAck_reg   <= inAck_next;
      trigOut_reg <= trigOut_next;
      dly_reg     <= dly_next;
      armed_reg   <= armed_next;
      trigd_reg   <= trigd_next;
      useIn_reg   <= useIn_next;
    end
  end

  assign trigInAck = inAck_reg;
  assign trigOut   = trigOut_reg;
  assign armed     = armed_reg;
  assign triggered = trigd_reg;
endmodule : logic_analyzer_cross_trigger

//--- sim/logic_analyzer_cross_trigger_asserts.sv
// Port checks for the capture core cross-trigger handshake
module xtrig_port_checker (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic armReq,
  input wire logic trigCond,
  input wire logic trigIn,
  input wire logic trigInAck,
  input wire logic trigOut,
  input wire logic trigOutAck,
  input wire logic armed,
  input wire logic triggered
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  chk_in_ack_rise: assert property (trigIn |=> trigInAck)
    else $error("input ack missing");
  chk_in_ack_fall: assert property (!trigIn |=> !trigInAck)
    else $error("input ack not released");
  chk_arm_take: assert property (armed && !armReq && (trigIn || trigCond)
    |=> !armed && triggered)
    else $error("trigger event not taken");
  chk_out_delay: assert property ($rose(triggered) |-> ##9 $rose(trigOut))
    else $error("trigger output delay wrong");
  chk_idle_keep: assert property (!armed && !armReq |=> $stable(triggered))
    else $error("event taken while disarmed");
  chk_out_hold: assert property (trigOut && !trigOutAck && !armReq
    |=> trigOut)
    else $error("trigger output dropped early");
  chk_out_ack: assert property (trigOut && trigOutAck |=> !trigOut)
    else $error("trigger output ignores ack");
  chk_rearm_drop: assert property (trigOut && armReq |=> !trigOut)
    else $error("rearm did not drop output");
  chk_rearm_set: assert property (armReq && !trigCond && !trigIn |=> armed)
    else $error("rearm did not arm");
  cover property ($rose(trigOut));
  cover property (trigOut && trigOutAck);
  cover property (trigOut && armReq);
  cover property ((trigIn && trigInAck) [*3]);
endmodule : xtrig_port_checker

bind logic_analyzer_cross_trigger xtrig_port_checker u_xtrig_port_checker (
  .ref_clk, .sys_rst, .armReq, .trigCond, .trigIn, .trigInAck, .trigOut,
  .trigOutAck, .armed, .triggered);

//--- sim/xtrig_peer_model.sv
// Far side: raises the trigger input and answers the trigger output
module xtrig_peer_model (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       fire,
  input  wire logic [3:0] inHold,
  input  wire logic [3:0] ackDelay,
  input  wire logic       ackOff,
  output logic            trigIn,
  input  wire logic       trigInAck,
  input  wire logic       trigOut,
  output logic            trigOutAck
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] inCnt;
  logic [3:0] ackCnt;
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      trigIn <= 1'b0;
      inCnt  <= 4'h0;
    end else if (fire) begin
      trigIn <= 1'b1;
      inCnt  <= 4'h0;
    end else if (trigIn && trigInAck) begin
      if (inCnt == inHold) trigIn <= 1'b0;
      inCnt <= inCnt + 4'h1;
    end
  end
  always @(posedge ref_clk) begin
    if (sys_rst || !trigOut) begin
      trigOutAck <= 1'b0;
      ackCnt     <= 4'h0;
    end else if (!ackOff && ackCnt == ackDelay) begin
      trigOutAck <= 1'b1;
    end else if (!ackOff) begin
      ackCnt <= ackCnt + 4'h1;
    end
  end
endmodule : xtrig_peer_model

//--- sim/logic_analyzer_cross_trigger_tb.sv
// Self-checking bench for the capture core cross-trigger handshake
module logic_analyzer_cross_trigger_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import xtrig_pkg::*;
  typedef struct packed {bit src; bit [3:0] dly, lat, fall;} row_t;
  localparam bit [3:0] LAT = 4'(OUT_DELAY);
  localparam row_t ROWS [4] = '{'{1'b0, 4'h0, LAT, 4'h2},
    '{1'b1, 4'h0, LAT, 4'h2}, '{1'b0, 4'h3, LAT, 4'h5},
    '{1'b1, 4'h7, LAT, 4'h9}};
  logic       ref_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       armReq = 1'b0, trigCond = 1'b0, fire = 1'b0, ackOff = 1'b0;
  logic [3:0] inHold = 4'h0, ackDelay = 4'h0;
  logic [2:0] scanSelect = 3'h1;
  logic       scanShift = 1'b0, scanTdi = 1'b0, scanUpdate = 1'b0, scanTdo;
  logic [15:0] rdWord;
  logic       trigIn, trigInAck, trigOut, trigOutAck, armed, triggered;
  int         mismatches = 0, compares = 0, cycles = 0, n;

  logic_analyzer_cross_trigger u_logic_analyzer_cross_trigger (
    .ref_clk, .sys_rst, .armReq, .trigCond, .trigIn, .trigInAck, .trigOut,
    .trigOutAck, .armed, .triggered, .scanSelect, .scanShift, .scanTdi,
    .scanUpdate, .scanTdo);
  xtrig_peer_model u_xtrig_peer_model (.ref_clk, .sys_rst, .fire, .inHold,
    .ackDelay, .ackOff, .trigIn, .trigInAck, .trigOut, .trigOutAck);

  always #10 ref_clk = ~ref_clk;
  // Hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      results();
    end
  end

  task automatic results();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic arm();
    armReq = 1'b1;
    tick(1);
    armReq = 1'b0;
    check(armed, 1);
  endtask : arm
  // Event edge ends the task; trigger input needs one more edge
  task automatic fire_event(input bit src);
    if (src) fire = 1'b1;
    else trigCond = 1'b1;
    tick(1);
    fire = 1'b0;
    trigCond = 1'b0;
    if (src) tick(1);
  endtask : fire_event
  task automatic wait_out(input logic lvl);
    n = 0;
    while (trigOut !== lvl && n < 40) begin
      tick(1);
      n++;
    end
  endtask : wait_out
  // one shift strobe every three hub cycles keeps the scan clock slow
  task automatic scan_word(input logic [15:0] w);
    for (int b = 0; b < 16; b++) begin
      scanTdi = w[b];
      scanShift = 1'b1;
      tick(1);
      scanShift = 1'b0;
      rdWord[b] = scanTdo;
      tick(2);
    end
    scanUpdate = 1'b1;
    tick(1);
    scanUpdate = 1'b0;
    tick(1);
  endtask : scan_word

  initial begin
    tick(8);
    check({trigOut, armed, triggered, trigInAck}, 0);
    sys_rst = 1'b0;
    foreach (ROWS[i]) begin
      ackDelay = ROWS[i].dly;
      arm();
      fire_event(ROWS[i].src);
      if (ROWS[i].src) check(trigInAck, 1);
      check({armed, triggered}, 1);
      wait_out(1'b1);
      check(16'(n), ROWS[i].lat);
      wait_out(1'b0);
      check(16'(n), ROWS[i].fall);
      $display("row %0d done", i);
    end
    inHold = 4'h5;
    fire_event(1'b1);
    tick(4);
    check(trigInAck, 1);
    tick(4);
    check(trigInAck, 0);
    check({trigOut, armed}, 0);
    $display("long input hold done");
    ackOff = 1'b1;
    arm();
    fire_event(1'b0);
    wait_out(1'b1);
    tick(20);
    check(trigOut, 1);
    arm();
    check(trigOut, 0);
    ackOff = 1'b0;
    $display("rearm without ack done");
    fire_event(1'b0);
    tick(3);
    sys_rst = 1'b1;
    tick(2);
    sys_rst = 1'b0;
    check({trigOut, armed, triggered}, 0);
    tick(12);
    check(trigOut, 0);
    $display("mid-run reset done");
    // Scan path: arm over the hub, ignore a foreign chain, then disarm
    scan_word(16'h0003);
    check(rdWord, 16'h0000);
    check(armed, 1);
    scanSelect = 3'h2;
    scan_word(16'h0006);
    check(armed, 1);
    scanSelect = 3'h1;
    scan_word(16'h0006);
    // Status {tick, useIn, trigOut, inAck, triggered, armed} after reset
    check(rdWord, 16'h0030);
    check(armed, 0);
    $display("scan path done");
    results();
  end
endmodule : logic_analyzer_cross_trigger_tb
